// ### rtl/hmf_pkg.sv
// Constants shared by the host MAC status/indirect-access block and its host.
// Assumes a 32-bit word bus where each register takes one aligned word.
package hmf_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0]  RX_FIFO_OCCUPANCY_OFS   = 8'h7c; // Fill of RX FIFOs
  localparam logic [7:0]  TX_FIFO_LEVELS_OFS      = 8'h80; // TX used/free
  localparam logic [7:0]  RX_DROPPED_COUNT_OFS    = 8'ha0; // Clear-on-read
  localparam logic [7:0]  INDIRECT_CMD_OFS        = 8'ha4; // Command + busy
  localparam logic [7:0]  INDIRECT_DATA_OFS       = 8'ha8; // Indirect data
  localparam logic [7:0]  INT_STATUS_OFS          = 8'hb0; // Sticky events
  localparam logic [7:0]  INT_MASK_OFS            = 8'hb4; // Enable mask
  // ==========================================================
  // Field positions
  localparam int          OCC_HI_LSB              = 16;    // Status words
  localparam int          BUSY_BIT                = 31;    // Busy handshake
  localparam int          DIR_BIT                 = 30;    // 1 read, 0 write
  localparam int          HALFWAY_BIT             = 23;    // Drop halfway irq
  // ==========================================================
  // Reset values and the drop halfway threshold
  localparam logic [15:0] TX_FREE_RESET           = 16'h1200; // Full FIFO
  localparam logic [31:0] DROP_HALF_BEFORE        = 32'h7fffffff;
  localparam logic [31:0] INT_MASK_RESET          = 32'h00000000;
  // ==========================================================
  // Timing of the internal register port
  localparam logic [3:0]  CSR_ACCESS_CYCLES       = 4'h4; // Busy length
endpackage

// ### rtl/hmf_if.sv
// Link between the status/indirect-access device and its host controller.
// Assumes a single clock shared by both ends; bus is classic SRAM-like.
`timescale 1ns/100ps
`default_nettype none
interface hmf_if (
  input wire logic clk_i,
  input wire logic rst_i
);
  logic        cs;     // Access strobe, held until ack
  logic        we;     // 1 write, 0 read
  logic [7:0]  addr;   // Byte offset
  logic [31:0] wdata;  // Write data
  logic [31:0] rdata;  // Read data from device
  logic        ack;    // One-cycle completion
  logic        irq;    // Level interrupt
  modport device (input cs, we, addr, wdata, output rdata, ack, irq);
  modport host   (output cs, we, addr, wdata, input rdata, ack, irq);
endinterface
`default_nettype wire

// ### rtl/hmf_device.sv
// Host MAC FIFO status, drop counter and indirect register access.
// Assumes FIFO levels and drop events come from logic on clk_i.
//
// Local design decision: the SRAM-like link (hmf_if) to the registers; Wishbone is in the host.
`timescale 1ns/100ps
`default_nettype none
module hmf_device (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  hmf_if.device            bus,
  input  wire logic [7:0]  rx_status_occupancy_i, // Words used
  input  wire logic [15:0] rx_frame_bytes_i,      // Length of stored frame
  input  wire logic        rx_frame_stored_i,     // Frame entered FIFO
  input  wire logic [15:0] rx_data_read_bytes_i,  // Bytes drained by host
  input  wire logic        rx_data_read_i,        // Drain strobe
  input  wire logic [7:0]  tx_status_occupancy_i, // Words used
  input  wire logic [15:0] tx_data_free_space_i,  // Bytes free
  input  wire logic        tx_free_valid_i,       // Free level is live
  input  wire logic        frame_dropped_i,       // Host MAC dropped frame
  output logic             csr_req_o,             // Internal access pulse
  output logic             csr_read_o,            // Internal direction
  output logic [7:0]       csr_index_o,           // Internal register index
  output logic [31:0]      csr_wdata_o,           // Internal write data
  input  wire logic [31:0] csr_rdata_i            // Internal read data
);
  // ==========================================================
  // Helpers
  // Round a byte count up to a whole 32-bit word
  function automatic logic [15:0] word_round(input logic [15:0] n);
    word_round = (n + 16'h0003) & 16'hfffc;
  endfunction

  // ==========================================================
  // Registers
  logic [15:0] rx_data_occupancy_ff;       // Byte fill of RX data FIFO
  logic [15:0] tx_free_ff;                 // Captured TX free space
  logic [31:0] dropped_frame_counter_ff;   // Drop count
  logic        busy_ff;                    // Indirect access in flight
  logic        dir_ff;                     // Last command direction
  logic [7:0]  index_ff;                   // Last command index
  logic [31:0] wdata_ff;                   // Host-written data
  logic [31:0] rdata_ff;                   // Internal read result
  logic [3:0]  busy_cnt_ff;                // Cycles left in access
  logic        ack_ff;                     // Bus answer
  logic [31:0] bus_rdata_ff;               // Registered read data
  logic        int_status_ff;              // Halfway sticky bit
  logic        int_mask_ff;                // Halfway enable

  // ==========================================================
  // Decode
  wire         req       = bus.cs & ~ack_ff;     // New access this cycle
  wire         wr        = req & bus.we;
  wire         rd        = req & ~bus.we;
  wire         sel_drop  = bus.addr == hmf_pkg::RX_DROPPED_COUNT_OFS;
  wire         sel_cmd   = bus.addr == hmf_pkg::INDIRECT_CMD_OFS;
  wire         sel_data  = bus.addr == hmf_pkg::INDIRECT_DATA_OFS;
  wire         sel_ist   = bus.addr == hmf_pkg::INT_STATUS_OFS;
  wire         sel_imk   = bus.addr == hmf_pkg::INT_MASK_OFS;
  // Start only when idle; a busy write is ignored to protect the access
  wire         start     = wr & sel_cmd & bus.wdata[hmf_pkg::BUSY_BIT]
                           & ~busy_ff;
  wire         done      = busy_ff & (busy_cnt_ff == 4'h1);
  wire         drop_rd   = rd & sel_drop;
  // Midpoint crossing event
  wire         halfway   = frame_dropped_i & ~drop_rd &
                 (dropped_frame_counter_ff == hmf_pkg::DROP_HALF_BEFORE);
  // Net change of RX data fill
  wire [15:0]  rx_add    = rx_frame_stored_i ?
                           word_round(rx_frame_bytes_i) : 16'h0000;
  wire [15:0]  rx_sub    = rx_data_read_i ?
                           word_round(rx_data_read_bytes_i) : 16'h0000;

  // Read mux; unused positions and unmapped offsets read zero
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case (bus.addr)
      hmf_pkg::RX_FIFO_OCCUPANCY_OFS: begin
        nxt_rdata = {8'h00, rx_status_occupancy_i,
                     rx_data_occupancy_ff};
      end
      hmf_pkg::TX_FIFO_LEVELS_OFS: begin
        nxt_rdata = {8'h00, tx_status_occupancy_i, tx_free_ff};
      end
      hmf_pkg::RX_DROPPED_COUNT_OFS: begin
        nxt_rdata = dropped_frame_counter_ff;
      end
      hmf_pkg::INDIRECT_CMD_OFS: begin
        nxt_rdata = {busy_ff, dir_ff, 22'h000000, index_ff};
      end
      hmf_pkg::INDIRECT_DATA_OFS: begin
        nxt_rdata = dir_ff ? rdata_ff : wdata_ff;
      end
      hmf_pkg::INT_STATUS_OFS: begin
        nxt_rdata = 32'(int_status_ff) << hmf_pkg::HALFWAY_BIT;
      end
      hmf_pkg::INT_MASK_OFS: begin
        nxt_rdata = 32'(int_mask_ff) << hmf_pkg::HALFWAY_BIT;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // ==========================================================
  // Bus answer: ack one cycle after strobe, then low for one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff       <= 1'b0;
      bus_rdata_ff <= 32'h00000000;
    end else begin
      ack_ff       <= req;
      bus_rdata_ff <= rd ? nxt_rdata : 32'h00000000;
    end
  end

  // ==========================================================
  // FIFO level tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_occupancy_ff <= 16'h0000;
      tx_free_ff           <= hmf_pkg::TX_FREE_RESET;
    end else begin
      rx_data_occupancy_ff <= rx_data_occupancy_ff + rx_add - rx_sub;
      // Until the TX FIFO reports, show full capacity
      if (tx_free_valid_i) begin
        tx_free_ff <= tx_data_free_space_i;
      end
    end
  end

  // ==========================================================
  // Drop counter; a drop coinciding with the read is kept as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dropped_frame_counter_ff <= 32'h00000000;
    end else if (drop_rd) begin
      dropped_frame_counter_ff <= {31'h0, frame_dropped_i};
    end else if (frame_dropped_i) begin
      dropped_frame_counter_ff <= dropped_frame_counter_ff + 32'h1;
    end
  end

  // ==========================================================
  // Interrupt status and mask; set wins over write-one-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status_ff <= 1'b0;
      int_mask_ff   <= hmf_pkg::INT_MASK_RESET[hmf_pkg::HALFWAY_BIT];
    end else begin
      if (halfway) begin
        int_status_ff <= 1'b1;
      end else if (wr & sel_ist & bus.wdata[hmf_pkg::HALFWAY_BIT]) begin
        int_status_ff <= 1'b0;
      end
      if (wr & sel_imk) begin
        int_mask_ff <= bus.wdata[hmf_pkg::HALFWAY_BIT];
      end
    end
  end

  // ==========================================================
  // Indirect access engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff     <= 1'b0;
      dir_ff      <= 1'b0;
      index_ff    <= 8'h00;
      wdata_ff    <= 32'h00000000;
      rdata_ff    <= 32'h00000000;
      busy_cnt_ff <= 4'h0;
    end else begin
      if (start) begin
        busy_ff     <= 1'b1;
        dir_ff      <= bus.wdata[hmf_pkg::DIR_BIT];
        index_ff    <= bus.wdata[7:0];
        busy_cnt_ff <= hmf_pkg::CSR_ACCESS_CYCLES;
      end else if (busy_ff) begin
        busy_cnt_ff <= busy_cnt_ff - 4'h1;
        if (done) begin
          busy_ff <= 1'b0;
          if (dir_ff) begin
            rdata_ff <= csr_rdata_i;
          end
        end
      end
      // Data writes while busy are dropped
      if (wr & sel_data & ~busy_ff) begin
        wdata_ff <= bus.wdata;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign bus.ack     = ack_ff;
  assign bus.rdata   = bus_rdata_ff;
  assign bus.irq     = int_status_ff & int_mask_ff;
  assign csr_req_o   = done;        // Sampled in last busy cycle
  assign csr_read_o  = dir_ff;
  assign csr_index_o = index_ff;
  assign csr_wdata_o = wdata_ff;
endmodule
`default_nettype wire

// ### rtl/hmf_host.sv
// Host controller: turns Wishbone orders into device bus cycles.
// Assumes a Wishbone classic master on clk_i and the device on the link.
`timescale 1ns/100ps
`default_nettype none
module hmf_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  hmf_if.host              bus,
  input  wire logic        wb_cyc_i,   // Wishbone cycle
  input  wire logic        wb_stb_i,   // Wishbone strobe
  input  wire logic        wb_we_i,    // Write enable
  input  wire logic [7:0]  wb_adr_i,   // Byte address
  input  wire logic [3:0]  wb_sel_i,   // Byte lanes (full words only)
  input  wire logic [31:0] wb_dat_i,   // Write data
  output logic [31:0]      wb_dat_o,   // Read data
  output logic             wb_ack_o,   // Acknowledge
  output logic             irq_o       // Device interrupt
);
  // ==========================================================
  // Protection state
  logic        busy_seen_ff;   // Device last reported busy
  logic        pend_ff;        // Device access outstanding
  logic        ack_ff;         // Wishbone answer
  logic [31:0] dat_ff;         // Captured read data

  wire wb_req    = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire to_guard  = (wb_adr_i == hmf_pkg::INDIRECT_CMD_OFS) |
                   (wb_adr_i == hmf_pkg::INDIRECT_DATA_OFS);
  // Writes to command/data while busy are refused locally
  wire blocked   = wb_we_i & to_guard & busy_seen_ff;
  wire bad_sel   = wb_we_i & (wb_sel_i != 4'hf);   // Partial writes dropped

  // ==========================================================
  // Tracking busy from command reads and own command writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_seen_ff <= 1'b0;
      pend_ff      <= 1'b0;
      ack_ff       <= 1'b0;
      dat_ff       <= 32'h00000000;
    end else begin
      ack_ff <= 1'b0;
      if (pend_ff & bus.ack) begin
        pend_ff <= 1'b0;
        ack_ff  <= 1'b1;
        dat_ff  <= bus.rdata;
        if (!wb_we_i && wb_adr_i == hmf_pkg::INDIRECT_CMD_OFS) begin
          busy_seen_ff <= bus.rdata[hmf_pkg::BUSY_BIT];
        end else if (wb_we_i && wb_adr_i == hmf_pkg::INDIRECT_CMD_OFS) begin
          busy_seen_ff <= wb_dat_i[hmf_pkg::BUSY_BIT];
        end
      end else if (wb_req & ~pend_ff) begin
        if (blocked | bad_sel) begin
          ack_ff <= 1'b1;
          dat_ff <= 32'h00000000;
        end else begin
          pend_ff <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Device side drive; held steady while outstanding
  assign bus.cs    = pend_ff & ~bus.ack;
  assign bus.we    = wb_we_i;
  assign bus.addr  = wb_adr_i;
  assign bus.wdata = wb_dat_i;
  assign wb_ack_o  = ack_ff;
  assign wb_dat_o  = dat_ff;
  assign irq_o     = bus.irq;
endmodule
`default_nettype wire

// ### verif/hmf_properties.sv
// Checker on the host-device link: bus answers, field layout, echoes.
// Assumes it sees the link signals of one joined host and device pair.
`timescale 1ns/100ps
`default_nettype none
module hmf_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cs,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        irq
);
  // ==========================================================
  // Decode of completed accesses
  logic        dir_ff;  // Last command direction
  logic [7:0]  idx_ff;  // Last command index
  logic [31:0] dat_ff;  // Last host data write
  logic        own_ff;  // Data register still holds a host value
  logic        unm_ff;  // Halfway mask bit as last written
  // Completion is the ack cycle: cs has already dropped, addr/we still held
  wire wr_done = we && ack;
  wire rd_done = !we && ack;
  wire wr_cmd  = wr_done && addr == hmf_pkg::INDIRECT_CMD_OFS;
  wire rd_cmd  = rd_done && addr == hmf_pkg::INDIRECT_CMD_OFS;
  wire rd_dat  = rd_done && addr == hmf_pkg::INDIRECT_DATA_OFS;
  wire mapped  = addr inside {8'h7c, 8'h80, 8'ha0, 8'ha4, 8'ha8, 8'hb0,
                              8'hb4};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of host writes; writes the host refuses never reach the link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_ff <= 1'b0;
      idx_ff <= 8'h00;
      dat_ff <= 32'h0;
      own_ff <= 1'b1;
      unm_ff <= 1'b0;
    end else begin
      // Only a write with the busy bit set launches and latches a command
      if (wr_cmd && wdata[hmf_pkg::BUSY_BIT]) begin
        dir_ff <= wdata[hmf_pkg::DIR_BIT];
        idx_ff <= wdata[7:0];
      end
      // A read command replaces the held data with the internal value
      if (wr_cmd && wdata[hmf_pkg::BUSY_BIT] && wdata[hmf_pkg::DIR_BIT])
        own_ff <= 1'b0;
      if (wr_done && addr == hmf_pkg::INDIRECT_DATA_OFS) begin
        dat_ff <= wdata;
        own_ff <= 1'b1;
      end
      // Taken edge, so a mask write is seen in the same cycle that irq can follow it
      if (cs && we && !ack && addr == hmf_pkg::INT_MASK_OFS)
        unm_ff <= wdata[hmf_pkg::HALFWAY_BIT];
    end
  end
  // ==========================================================
  // Properties
  sequence s_taken;
    cs && !ack;
  endsequence
  sequence s_answer;
    ack && $stable(addr) && $stable(we);
  endsequence
  AST_ACK_FOLLOWS: assert property (s_taken |=> s_answer)
    else $error("link request not answered in the next cycle");
  AST_ACK_CAUSED: assert property (ack |-> $past(cs) && !$past(ack))
    else $error("link ack without a fresh request");
  AST_RX_RSV: assert property (rd_done && addr == 8'h7c |->
    rdata[31:24] == 8'h00) else $error("rx occupancy top byte not zero");
  AST_TX_RSV: assert property (rd_done && addr == 8'h80 |->
    rdata[31:24] == 8'h00) else $error("tx levels top byte not zero");
  AST_CMD_FIELDS: assert property (rd_cmd |->
    rdata[30:0] == {dir_ff, 22'h0, idx_ff})
    else $error("command read back differs from last command");
  AST_DATA_ECHO: assert property (rd_dat && own_ff && !dir_ff |->
    rdata == dat_ff) else $error("data register lost host write");
  AST_UNMAPPED: assert property (rd_done && !mapped |->
    rdata == 32'h0) else $error("unmapped read not zero");
  AST_IRQ_MASKED: assert property (irq |-> unm_ff)
    else $error("interrupt raised with every mask bit clear");
endmodule
`default_nettype wire

// ### verif/test_host_mac_fifo_status_csr_access.sv
// Bench joining host controller and device; reads checked against a model.
// Assumes package, link, both ends and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_host_mac_fifo_status_csr_access;
  // ==========================================================
  // Stimulus, observation and model state
  logic        clk_i, rst_i, cyc, stb, we, stored, drained, fvalid, dropped;
  logic [7:0]  adr, rx_st, tx_st;
  logic [3:0]  sel;       // Wishbone byte lanes
  logic [15:0] flen, dlen, tx_free, free_m;
  logic [31:0] wdat, rdat, csr_rd, r;
  logic        ack, irq, req, rd_o;
  logic [7:0]  idx_o;
  logic [31:0] wd_o;
  logic [40:0] req_q[$];  // Internal accesses seen
  int          rx_used, len, cycles, n_mismatch, comparisons;
  hmf_if hmf_if_i (.clk_i(clk_i), .rst_i(rst_i));
  hmf_device hmf_device_i (.clk_i(clk_i), .rst_i(rst_i), .bus(hmf_if_i),
    .rx_status_occupancy_i(rx_st), .rx_frame_bytes_i(flen),
    .rx_frame_stored_i(stored), .rx_data_read_bytes_i(dlen),
    .rx_data_read_i(drained), .tx_status_occupancy_i(tx_st),
    .tx_data_free_space_i(tx_free), .tx_free_valid_i(fvalid),
    .frame_dropped_i(dropped), .csr_req_o(req), .csr_read_o(rd_o),
    .csr_index_o(idx_o), .csr_wdata_o(wd_o), .csr_rdata_i(csr_rd));
  hmf_host hmf_host_i (.clk_i(clk_i), .rst_i(rst_i), .bus(hmf_if_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq));
  hmf_properties hmf_properties_i (.clk_i(clk_i), .rst_i(rst_i),
    .cs(hmf_if_i.cs), .we(hmf_if_i.we), .addr(hmf_if_i.addr),
    .wdata(hmf_if_i.wdata), .rdata(hmf_if_i.rdata), .ack(hmf_if_i.ack),
    .irq(hmf_if_i.irq));
  // ==========================================================
  // Clock, hang limit and internal access monitor
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (req === 1'b1)
      req_q.push_back({rd_o, idx_o, wd_o});
    if (cycles > 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  // ==========================================================
  // Wishbone classic cycle; holds everything until ack is sampled
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    comparisons++;
    if (q !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t read %h got %h want %h", $time, a, q, exp);
    end
  endtask
  task automatic chk_val(input logic [40:0] got, input logic [40:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t port got %h want %h", $time, got, exp);
    end
  endtask
  // One indirect access, polled to completion, then read back
  task automatic indirect(input logic rd, input logic [7:0] idx,
                          input logic [31:0] d);
    logic [31:0] q;
    logic [31:0] s;
    logic [40:0] e;
    s = $urandom;
    csr_rd <= d;
    if (!rd)
      wb_xfer(1'b1, hmf_pkg::INDIRECT_DATA_OFS, d, q);
    wb_xfer(1'b1, hmf_pkg::INDIRECT_CMD_OFS, {1'b1, rd, s[21:0], idx}, q);
    // Data write during the access must be swallowed by the host
    wb_xfer(1'b1, hmf_pkg::INDIRECT_DATA_OFS, ~d, q);
    q = 32'hffffffff;
    while (q[31] !== 1'b0)
      wb_xfer(1'b0, hmf_pkg::INDIRECT_CMD_OFS, 32'h0, q);
    chk_val(41'(req_q.size()), 41'h1);
    e = (req_q.size() > 0) ? req_q.pop_front() : 'x;
    chk_val({e[40:32], rd ? d : e[31:0]}, {rd, idx, d});
    req_q.delete();
    chk_reg(hmf_pkg::INDIRECT_CMD_OFS, {1'b0, rd, 22'h0, idx});
    chk_reg(hmf_pkg::INDIRECT_DATA_OFS, d);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {clk_i, cyc, stb, we, stored, drained, fvalid, dropped} = 8'h00;
    {adr, rx_st, tx_st, flen, dlen, tx_free, wdat, csr_rd} = 'h0;
    sel = 4'hf;
    rst_i = 1'b1;
    void'($urandom(20823));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_reg(hmf_pkg::TX_FIFO_LEVELS_OFS, 32'h00001200);
    chk_reg(hmf_pkg::RX_FIFO_OCCUPANCY_OFS, 32'h0);
    chk_reg(8'h04, 32'h0);
    $display("test reset done");
    r = $urandom;
    free_m = r[31:16];
    {tx_free, tx_st, rx_st} <= r;
    fvalid <= 1'b1;
    // Back-to-back stored frames of random lengths, 1 to 1600 bytes
    repeat (6) begin
      len = $urandom_range(1, 1600);
      flen <= len[15:0];
      stored <= 1'b1;
      rx_used += (len + 3) & ~3;
      @(posedge clk_i);
    end
    len = $urandom_range(1, 20);
    dlen <= len[15:0];
    drained <= 1'b1;
    stored <= 1'b0;
    rx_used -= (len + 3) & ~3;
    fvalid <= 1'b0;
    @(posedge clk_i);
    drained <= 1'b0;
    tx_free <= ~free_m;
    wb_xfer(1'b1, hmf_pkg::TX_FIFO_LEVELS_OFS, 32'hffffffff, r);
    chk_reg(8'h7c, {8'h00, rx_st, 16'(rx_used)});
    chk_reg(8'h80, {8'h00, tx_st, free_m});
    $display("test levels done");
    len = $urandom_range(3, 20);
    dropped <= 1'b1;
    repeat (len) @(posedge clk_i);
    dropped <= 1'b0;
    @(posedge clk_i);
    chk_reg(hmf_pkg::RX_DROPPED_COUNT_OFS, 32'(len));
    chk_reg(hmf_pkg::RX_DROPPED_COUNT_OFS, 32'h0);
    $display("test drops done");
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      indirect(i[0], r[7:0], $urandom);
    end
    $display("test indirect done");
    wb_xfer(1'b1, hmf_pkg::INT_MASK_OFS, 32'h00800000, r);
    // Partial-lane write is refused by the host, so the mask survives
    sel <= 4'h3;
    wb_xfer(1'b1, hmf_pkg::INT_MASK_OFS, 32'h0, r);
    sel <= 4'hf;
    wb_xfer(1'b1, hmf_pkg::INT_STATUS_OFS, 32'hffffffff, r);
    chk_reg(hmf_pkg::INT_MASK_OFS, 32'h00800000);
    chk_reg(hmf_pkg::INT_STATUS_OFS, 32'h0);
    chk_val(41'(irq), 41'h0);
    $display("test interrupt done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
